// ---- gpe_pkg.sv ----
package gpe_pkg;

  // ==========================================================================
  // register offsets (byte addresses on the bus)
  localparam logic [7:0] OFS_PIN_LEVEL  = 8'h00;
  localparam logic [7:0] OFS_LATCH      = 8'h04;
  localparam logic [7:0] OFS_DIR_STATUS = 8'h08;
  localparam logic [7:0] OFS_ANALOG_CFG = 8'h0c;
  localparam logic [7:0] OFS_PAR_WORD   = 8'h10;
  localparam logic [7:0] OFS_PAR_FLAG   = 8'h14;

  // ==========================================================================
  // field positions
  localparam int BIT_IBF        = 7;
  localparam int BIT_OBF        = 6;
  localparam int BIT_OVF        = 5;
  localparam int BIT_MODE       = 4;
  localparam int BIT_INPUT_ONLY = 3;
  localparam int BIT_IRQ_FLAG   = 0;
  localparam int PIN_CNT        = 3;
  localparam int ANALOG_W       = 6;
  localparam int WORD_W         = 8;

  // ==========================================================================
  // reset values and decode constants
  localparam logic [2:0]          DIR_RESET     = 3'h7;
  localparam logic [2:0]          LATCH_RESET   = 3'h0;
  localparam logic [ANALOG_W-1:0] ANALOG_RESET  = 6'h00;
  localparam logic [3:0]          DIGITAL_MIN   = 4'ha;
  localparam logic [1:0]          HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]          HRESP_OKAY    = 2'h0;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic cs_n;
  } gpe_par_ctl_t;

  typedef struct packed {
    logic              rd_word;
    logic              wr_word;
    logic [WORD_W-1:0] wdata;
    logic              clr_ovf;
    logic              clr_irq;
  } gpe_par_sw_t;

  typedef struct packed {
    logic input_buffer_full;
    logic output_buffer_full;
    logic ovf;
    logic irq;
  } gpe_par_flags_t;

  typedef struct packed {
    logic              wr_act;
    logic              rd_act;
    logic [WORD_W-1:0] in_word;
    logic [WORD_W-1:0] out_word;
    gpe_par_flags_t    flags;
    logic              data_oe_n;
  } gpe_par_state_t;

  typedef struct packed {
    logic [2:0]          latch;
    logic [2:0]          dir;
    logic                mode;
    logic [ANALOG_W-1:0] analog;
    logic                wr_pend;
    logic                rd_pend;
    logic [7:0]          addr;
    logic                hreadyout;
    logic [31:0]         hrdata;
    logic [1:0]          hresp;
    logic [2:0]          pin_out;
    logic [2:0]          pin_oe_n;
    logic                master_clear_req;
  } gpe_state_t;

endpackage : gpe_pkg

// ---- gpe_par_ctrl.sv ----
module gpe_par_ctrl
  import gpe_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              enable,
  input  wire gpe_par_ctl_t      ctl,
  input  wire logic [WORD_W-1:0] data_in,
  input  wire gpe_par_sw_t       sw,
  output gpe_par_flags_t         flags,
  output logic [WORD_W-1:0]      in_word,
  output logic [WORD_W-1:0]      out_word,
  output logic                   data_oe_n
);

  gpe_par_state_t s_reg;
  gpe_par_state_t s_next;
  logic           wr_now;
  logic           rd_now;

  // ==========================================================================
  // cycle detection on the control inputs (active low, sampled each clock)
  always_comb begin
    wr_now = enable & ~ctl.cs_n & ~ctl.wr_n;
    rd_now = enable & ~ctl.cs_n & ~ctl.rd_n;
    s_next = s_reg;
    s_next.wr_act = wr_now;
    s_next.rd_act = rd_now;
    // keep the last value seen while the write is open
    if (wr_now) begin
      s_next.in_word = data_in;
    end
    // software side first so that hardware events below win a tie
    if (sw.rd_word) begin
      s_next.flags.input_buffer_full = 1'b0;
    end
    if (sw.clr_ovf) begin
      s_next.flags.ovf = 1'b0;
    end
    if (sw.clr_irq) begin
      s_next.flags.irq = 1'b0;
    end
    // a word written during an open read goes out at once, no full flag
    if (sw.wr_word) begin
      s_next.out_word = sw.wdata;
      if (!(rd_now || s_reg.rd_act)) begin
        s_next.flags.output_buffer_full = 1'b1;
      end
    end
    // end of an external write
    if (s_reg.wr_act && !wr_now) begin
      if (s_reg.flags.input_buffer_full && !sw.rd_word) begin
        s_next.flags.ovf = 1'b1;
      end
      s_next.flags.input_buffer_full = 1'b1;
      s_next.flags.irq = 1'b1;
    end
    // start of an external read empties the output buffer
    if (rd_now && !s_reg.rd_act) begin
      s_next.flags.output_buffer_full = 1'b0;
    end
    // end of an external read raises the flag, pins go back to input
    if (s_reg.rd_act && !rd_now) begin
      s_next.flags.irq = 1'b1;
    end
    s_next.data_oe_n = ~rd_now;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.data_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags     = s_reg.flags;
  assign in_word   = s_reg.in_word;
  assign out_word  = s_reg.out_word;
  assign data_oe_n = s_reg.data_oe_n;

endmodule : gpe_par_ctrl

// ---- gpe_port.sv ----
// Overview of operation
// - large package: four-bit port, three pins each settable as input or output
// - pin chosen as analog reads zero, digital input path off
// - direction one releases the pin, zero drives the latch value
// - direction keeps steering drivers in analog use; software keeps inputs
// - after reset the three configurable pins are analog inputs
// - latch register reads back latched values, not pin levels
// - fourth pin input only: digital input, or master clear when fuse set
// - fourth pin is a digital input after reset only with fuse clear
// - small package: port is only the fourth pin, and only fuse clear
// - bit 7 read-only, one while a received word waits for software
// - bit 6 read-only, one while written word is unread outside
// - bit 5 set on write over unread word, cleared by software only
// - bit 4 selects parallel client mode when one, plain port when zero
// - parallel mode, inputs: pins are read, write and chip select
// - output mode drives latch bit even when analog is selected
// - unimplemented bits of port, latch and direction read zero
// - end of external write sets interrupt flag and input-full bit
// - external read start presents data and clears output-full bit
module gpe_port
  import gpe_pkg::*;
#(
  parameter logic LARGE_PACKAGE = 1'b1
)(
  input  wire logic              clock,
  input  wire logic              reset,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic [1:0]             hresp,
  // configurable pins
  input  wire logic [2:0]        port_pin_in,
  output logic [2:0]             port_pin_out,
  output logic [2:0]             port_pin_oe_n,
  // input-only pin and its configuration
  input  wire logic              input_only_pin,
  input  wire logic              master_clear_enable_fuse,
  output logic                   master_clear_req,
  // parallel data port
  input  wire logic [WORD_W-1:0] parallel_data_in,
  output logic [WORD_W-1:0]      parallel_data_out,
  output logic                   parallel_data_oe_n
);

  // ==========================================================================
  // decode helpers
  // all three pins count as analog while the field sits below the digital range
  function automatic logic analog_on(input logic [ANALOG_W-1:0] cfg);
    analog_on = (cfg[3:0] < DIGITAL_MIN);
  endfunction : analog_on

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction : is_addr

  gpe_state_t     s_reg;
  gpe_state_t     s_next;
  gpe_par_sw_t    par_sw;
  gpe_par_ctl_t   par_ctl;
  gpe_par_flags_t par_flags;
  logic [7:0]     par_in_word;
  logic [7:0]     par_out_word;
  logic           par_enable;
  logic           addr_phase;
  logic           commit_wr;
  logic [7:0]     pin_level;
  logic [31:0]    read_value;

  // ==========================================================================
  // pin level view
  always_comb begin
    pin_level = 8'h00;
    if (LARGE_PACKAGE) begin
      // analog selection blanks the digital input path
      pin_level[2:0] = analog_on(s_reg.analog) ? 3'h0 : port_pin_in;
    end
    // fourth pin reads only when it is not the master clear
    pin_level[BIT_INPUT_ONLY] = ~master_clear_enable_fuse & input_only_pin;
  end

  // ==========================================================================
  // parallel client control: pins become read, write and chip select
  // only with the mode bit, all three inputs and digital buffers enabled
  assign par_enable = LARGE_PACKAGE & s_reg.mode & (&s_reg.dir)
                    & ~analog_on(s_reg.analog);
  assign par_ctl.rd_n = port_pin_in[0];
  assign par_ctl.wr_n = port_pin_in[1];
  assign par_ctl.cs_n = port_pin_in[2];

  gpe_par_ctrl u_par_ctrl (
    .clock     (clock),
    .reset     (reset),
    .enable    (par_enable),
    .ctl       (par_ctl),
    .data_in   (parallel_data_in),
    .sw        (par_sw),
    .flags     (par_flags),
    .in_word   (par_in_word),
    .out_word  (par_out_word),
    .data_oe_n (parallel_data_oe_n)
  );

  assign parallel_data_out = par_out_word;

  // ==========================================================================
  // bus phases: writes commit at the end of their data phase, reads take
  // one wait state so the value reflects any write that just committed
  assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign commit_wr  = s_reg.wr_pend & hready;

  // software events towards the parallel controller
  always_comb begin
    par_sw         = '0;
    par_sw.wdata   = hwdata[WORD_W-1:0];
    par_sw.rd_word = s_reg.rd_pend & is_addr(s_reg.addr, OFS_PAR_WORD) & LARGE_PACKAGE;
    if (commit_wr && LARGE_PACKAGE) begin
      par_sw.wr_word = is_addr(s_reg.addr, OFS_PAR_WORD);
      // overflow bit clears only when software writes zero to it
      par_sw.clr_ovf = is_addr(s_reg.addr, OFS_DIR_STATUS) & ~hwdata[BIT_OVF];
      // write one to clear the parallel interrupt flag
      par_sw.clr_irq = is_addr(s_reg.addr, OFS_PAR_FLAG) & hwdata[BIT_IRQ_FLAG];
    end
  end

  // ==========================================================================
  // read multiplexer
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (1'b1)
      is_addr(s_reg.addr, OFS_PIN_LEVEL): begin
        read_value[7:0] = pin_level;
      end
      is_addr(s_reg.addr, OFS_LATCH): begin
        // latch, not pins, so read-modify-write keeps driven values
        if (LARGE_PACKAGE) begin
          read_value[2:0] = s_reg.latch;
        end
      end
      is_addr(s_reg.addr, OFS_DIR_STATUS): begin
        if (LARGE_PACKAGE) begin
          read_value[BIT_IBF]  = par_flags.input_buffer_full;
          read_value[BIT_OBF]  = par_flags.output_buffer_full;
          read_value[BIT_OVF]  = par_flags.ovf;
          read_value[BIT_MODE] = s_reg.mode;
          read_value[2:0]      = s_reg.dir;
        end
      end
      is_addr(s_reg.addr, OFS_ANALOG_CFG): begin
        read_value[ANALOG_W-1:0] = s_reg.analog;
      end
      is_addr(s_reg.addr, OFS_PAR_WORD): begin
        if (LARGE_PACKAGE) begin
          read_value[WORD_W-1:0] = par_in_word;
        end
      end
      is_addr(s_reg.addr, OFS_PAR_FLAG): begin
        if (LARGE_PACKAGE) begin
          read_value[BIT_IRQ_FLAG] = par_flags.irq;
        end
      end
      default: begin
        // unmapped address reads zero
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_next       = s_reg;
    s_next.hresp = HRESP_OKAY;

    // commit a pending write with the data now on the bus
    if (commit_wr) begin
      s_next.wr_pend = 1'b0;
      if (LARGE_PACKAGE) begin
        // writing the pin view lands in the latch, like the latch itself
        if (is_addr(s_reg.addr, OFS_PIN_LEVEL) || is_addr(s_reg.addr, OFS_LATCH)) begin
          s_next.latch = hwdata[2:0];
        end
        if (is_addr(s_reg.addr, OFS_DIR_STATUS)) begin
          s_next.dir  = hwdata[2:0];
          s_next.mode = hwdata[BIT_MODE];
        end
      end
      if (is_addr(s_reg.addr, OFS_ANALOG_CFG)) begin
        s_next.analog = hwdata[ANALOG_W-1:0];
      end
    end

    // second cycle of a read: load data, release the bus
    if (s_reg.rd_pend) begin
      s_next.rd_pend   = 1'b0;
      s_next.hrdata    = read_value;
      s_next.hreadyout = 1'b1;
    end

    // new address phase; only whole-word single transfers are expected
    if (addr_phase) begin
      s_next.addr = haddr[7:0];
      if (hwrite) begin
        s_next.wr_pend = 1'b1;
      end else begin
        s_next.rd_pend   = 1'b1;
        s_next.hreadyout = 1'b0;
      end
    end

    // drivers follow direction even in analog use; latch goes out untouched
    if (LARGE_PACKAGE) begin
      s_next.pin_out  = s_next.latch;
      s_next.pin_oe_n = s_next.dir;
    end else begin
      s_next.pin_out  = 3'h0;
      s_next.pin_oe_n = 3'h7;
    end

    // pin is active low; clear request only when the fuse enables it
    s_next.master_clear_req = master_clear_enable_fuse & ~input_only_pin;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_reg           <= '0;
      s_reg.latch     <= LATCH_RESET;
      s_reg.dir       <= DIR_RESET;
      s_reg.analog    <= ANALOG_RESET;
      s_reg.hreadyout <= 1'b1;
      s_reg.hresp     <= HRESP_OKAY;
      s_reg.pin_oe_n  <= 3'h7;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata           = s_reg.hrdata;
  assign hreadyout        = s_reg.hreadyout;
  assign hresp            = s_reg.hresp;
  assign port_pin_out     = s_reg.pin_out;
  assign port_pin_oe_n    = s_reg.pin_oe_n;
  assign master_clear_req = s_reg.master_clear_req;

endmodule : gpe_port

// ---- gpe_port_assertions.sv ----
module gpe_port_assertions
  import gpe_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [2:0]  port_pin_in,
  input wire logic [2:0]  port_pin_out,
  input wire logic [2:0]  port_pin_oe_n,
  input wire logic        input_only_pin,
  input wire logic        master_clear_enable_fuse,
  input wire logic        master_clear_req,
  input wire logic        parallel_data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ==========================================================================
  // request tracking
  logic take;
  logic dir_q;
  logic lat_q;
  assign take = hsel && hready && htrans == HTRANS_NONSEQ;

  // mark the data phase of a write; both latch offsets land on the same latch
  always_ff @(posedge clock) begin
    dir_q <= !reset && take && hwrite && haddr[7:0] == OFS_DIR_STATUS;
    lat_q <= !reset && take && hwrite
             && (haddr[7:0] == OFS_LATCH || haddr[7:0] == OFS_PIN_LEVEL);
  end

  sequence rd_taken;
    take && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  // ==========================================================================
  // properties
  chk_read_wait: assert property (rd_taken |=> one_wait)
    else $error("read wait state is not exactly one cycle");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  chk_dir_to_oe: assert property (dir_q |->
    ##1 port_pin_oe_n == $past(hwdata[2:0]))
    else $error("pin enables do not follow the direction write");
  chk_latch_to_pin: assert property (lat_q |->
    ##1 port_pin_out == $past(hwdata[2:0]))
    else $error("pin outputs do not follow the latch write");
  chk_reset_pins: assert property ($past(reset) |->
    {port_pin_oe_n, port_pin_out} == 6'h38)
    else $error("pins not released after reset");
  chk_master_clear_pin_follow: assert property (!$past(reset) |->
    master_clear_req == $past(master_clear_enable_fuse && !input_only_pin))
    else $error("master clear request does not follow its pin");
  chk_read_drive: assert property (!parallel_data_oe_n |->
    $past(!port_pin_in[2] && !port_pin_in[0]))
    else $error("data bus driven without an external read");
  chk_read_release: assert property (!parallel_data_oe_n && port_pin_in[0] |->
    ##1 parallel_data_oe_n)
    else $error("data bus not released after the read");
endmodule : gpe_port_assertions

bind gpe_port gpe_port_assertions u_gpe_chk (
  .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .port_pin_in, .port_pin_out, .port_pin_oe_n, .input_only_pin,
  .master_clear_enable_fuse, .master_clear_req, .parallel_data_oe_n
);

// ---- gpe_ext_host.sv ----
module gpe_ext_host
  import gpe_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [WORD_W-1:0] parallel_data_out,
  input  wire logic              parallel_data_oe_n,
  output gpe_par_ctl_t           ctl,
  output logic [WORD_W-1:0]      data_to_port
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // idle strobes sit high as if pulled up
  initial begin
    ctl          = '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1};
    data_to_port = 8'h00;
  end

  task automatic set_levels(input logic [2:0] v);
    @(posedge clock);
    ctl <= '{rd_n: v[0], wr_n: v[1], cs_n: v[2]};
  endtask : set_levels

  // write cycle; a short hold gives a prompt host, a long one a slow host
  task automatic ext_write(input logic [WORD_W-1:0] d, input int hold);
    @(posedge clock);
    ctl.cs_n     <= 1'b0;
    ctl.wr_n     <= 1'b0;
    data_to_port <= d;
    repeat (hold) @(posedge clock);
    ctl.cs_n     <= 1'b1;
    ctl.wr_n     <= 1'b1;
    data_to_port <= ~d; // released bus must not keep showing the word
    repeat (2) @(posedge clock);
  endtask : ext_write

  // read cycle; an undriven bus reads back unknown so it never matches
  task automatic ext_read(output logic [WORD_W-1:0] d, input int hold);
    @(posedge clock);
    ctl.cs_n <= 1'b0;
    ctl.rd_n <= 1'b0;
    repeat (hold) @(posedge clock);
    @(negedge clock);
    d = parallel_data_oe_n ? 8'hxx : parallel_data_out;
    @(posedge clock);
    ctl.cs_n <= 1'b1;
    ctl.rd_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : ext_read
endmodule : gpe_ext_host

// ---- gpe_port_tb_top.sv ----
module gpe_port_tb_top
  import gpe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       hrdata;
  logic [1:0]        hresp;
  logic              hreadyout;
  logic              input_only_pin = 1'b1;
  logic              master_clear_enable_fuse = 1'b0;
  logic              master_clear_req;
  logic [2:0]        port_pin_in;
  logic [2:0]        port_pin_out;
  logic [2:0]        port_pin_oe_n;
  logic [WORD_W-1:0] parallel_data_in;
  logic [WORD_W-1:0] parallel_data_out;
  logic              parallel_data_oe_n;
  gpe_par_ctl_t      ext_ctl;
  logic [31:0]       rd_v;
  logic [7:0]        ext_v;
  int                mismatches = 0;
  int                checked = 0;

  always #10 clock = ~clock;

  // a driven pin shows the latch, a released one the outside host
  assign port_pin_in = (port_pin_oe_n & {ext_ctl.cs_n, ext_ctl.wr_n, ext_ctl.rd_n})
                     | (~port_pin_oe_n & port_pin_out);

  gpe_port DUT (
    .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_pin_in, .port_pin_out,
    .port_pin_oe_n, .input_only_pin, .master_clear_enable_fuse, .master_clear_req,
    .parallel_data_in, .parallel_data_out, .parallel_data_oe_n
  );

  gpe_ext_host host (
    .clock, .parallel_data_out, .parallel_data_oe_n, .ctl(ext_ctl),
    .data_to_port(parallel_data_in)
  );

  // ==========================================================================
  // checking and bus tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : cmp

  task automatic results();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // ready is judged at the settled negedge, then the sampling edge passes
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clock);
    while (hreadyout !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) begin
      mismatches++;
      results();
    end
    d = hrdata;
    @(posedge clock);
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy(rd_v);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd_v);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd_v, exp);
    // the slave never signals an error
    cmp({30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask : rc

  // pin outputs load on the same edge as the register behind them
  task automatic pins(input logic mc, input logic [2:0] oe, input logic [2:0] po);
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp({24'h0, master_clear_req, port_pin_oe_n, 1'b0, port_pin_out},
        {24'h0, mc, oe, 1'b0, po});
    @(posedge clock);
  endtask : pins

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rc(OFS_DIR_STATUS, 32'h07);
    rc(OFS_PIN_LEVEL, 32'h08);
    rc(OFS_LATCH, 32'h00);
    rc(OFS_ANALOG_CFG, 32'h00);
    rc(8'h20, 32'h00);
    wr(OFS_LATCH, 32'hff);
    rc(OFS_LATCH, 32'h07);
    wr(OFS_PIN_LEVEL, 32'h05);
    rc(OFS_LATCH, 32'h05);
    // outputs while the pins are still analog
    wr(OFS_DIR_STATUS, 32'h00);
    pins(1'b0, 3'h0, 3'h5);
    rc(OFS_PIN_LEVEL, 32'h08);
    wr(OFS_ANALOG_CFG, 32'hff);
    rc(OFS_ANALOG_CFG, 32'h3f);
    rc(OFS_PIN_LEVEL, 32'h0d);
    // inputs: port reads pins, latch reads the latch
    wr(OFS_DIR_STATUS, 32'h07);
    host.set_levels(3'b010);
    rc(OFS_PIN_LEVEL, 32'h0a);
    rc(OFS_LATCH, 32'h05);
    wr(OFS_ANALOG_CFG, 32'h09);
    rc(OFS_PIN_LEVEL, 32'h08);
    input_only_pin <= 1'b0;
    wr(OFS_ANALOG_CFG, 32'h0a);
    rc(OFS_PIN_LEVEL, 32'h02);
    master_clear_enable_fuse <= 1'b1;
    pins(1'b1, 3'h7, 3'h5);
    // a high pin must still read zero while it serves as master clear
    input_only_pin <= 1'b1;
    rc(OFS_PIN_LEVEL, 32'h02);
    master_clear_enable_fuse <= 1'b0;
    host.set_levels(3'b111);
    // parallel client traffic
    wr(OFS_DIR_STATUS, 32'hff);
    rc(OFS_DIR_STATUS, 32'h17);
    host.ext_write(8'ha5, 3);
    rc(OFS_DIR_STATUS, 32'h97);
    rc(OFS_PAR_FLAG, 32'h01);
    host.ext_write(8'h3c, 1);
    rc(OFS_DIR_STATUS, 32'hb7);
    rc(OFS_PAR_WORD, 32'h3c);
    rc(OFS_DIR_STATUS, 32'h37);
    // status bits ignore writes, a one in the overflow bit keeps it
    wr(OFS_DIR_STATUS, 32'hf7);
    rc(OFS_DIR_STATUS, 32'h37);
    wr(OFS_DIR_STATUS, 32'h17);
    rc(OFS_DIR_STATUS, 32'h17);
    wr(OFS_PAR_FLAG, 32'h01);
    rc(OFS_PAR_FLAG, 32'h00);
    wr(OFS_PAR_WORD, 32'h5a);
    rc(OFS_DIR_STATUS, 32'h57);
    host.ext_read(ext_v, 2);
    cmp({24'h0, ext_v}, 32'h5a);
    rc(OFS_DIR_STATUS, 32'h17);
    rc(OFS_PAR_FLAG, 32'h01);
    wr(OFS_DIR_STATUS, 32'h07);
    host.ext_write(8'h11, 2);
    rc(OFS_DIR_STATUS, 32'h07);
    results();
  end
endmodule : gpe_port_tb_top
